// >>> inc/e1ai_cfg.svh
// Offsets, field positions, reset values and timing counts of the E1 alarm/interrupt block.
// Assumes one 200 MHz clock; line timing arrives as bit and frame strobes.
`ifndef E1AI_CFG_SVH
`define E1AI_CFG_SVH

`define E1AI_ADDR_W        4
`define E1AI_DATA_W        8

`define E1AI_OFS_BLOCK_EN  4'h0
`define E1AI_OFS_STATUS    4'h1
`define E1AI_OFS_EVENT     4'h2
`define E1AI_OFS_EVENT_CLR 4'h3
`define E1AI_OFS_EVENT_EN  4'h4
`define E1AI_OFS_FRAMING   4'h5

`define E1AI_BIT_FRAMER_BLK 0
`define E1AI_BIT_ALARM_BLK  1

`define E1AI_BIT_OOF_STATE  7
`define E1AI_BIT_AIS_STATE  6
`define E1AI_BIT_MYEL_CHG   5
`define E1AI_BIT_SIGNAL_LOSS_STATE  4

`define E1AI_EV_OOF         0
`define E1AI_EV_AIS         1
`define E1AI_EV_MYEL        2
`define E1AI_EV_LOS         3
`define E1AI_EV_W           4
`define E1AI_EV_FRAMER_MASK 4'h5
`define E1AI_EV_ALARM_MASK  4'ha

`define E1AI_RST_BLOCK_EN   2'h0
`define E1AI_RST_EVENT_EN   4'h0
`define E1AI_RST_THRESHOLD  3'h2

`define E1AI_FRAME_NS       125000
`define E1AI_AIS_TIME_NS    250000
`define E1AI_AIS_FRAMES     (`E1AI_AIS_TIME_NS / `E1AI_FRAME_NS)
`define E1AI_AIS_ZERO_MAX   2
`define E1AI_LOS_BITS       175
`define E1AI_LOS_ONES_MIN   22

`endif

// >>> inc/e1ai_pkg.sv
// Types shared by the E1 alarm/interrupt block.
// Numbers live in e1ai_cfg.svh.
package e1ai_pkg;

  typedef enum logic [1:0] {
    E1AI_LOS_CLEAR,
    E1AI_LOS_DECLARED
  } e1ai_los_t;

  typedef enum logic [1:0] {
    E1AI_SEL_NONE,
    E1AI_SEL_STATUS,
    E1AI_SEL_OTHER
  } e1ai_sel_t;

endpackage

// >>> logic/e1ai_run_count.sv
// Saturating counter of consecutive qualifying steps.
// Assumes step is a one-cycle strobe; done holds while the run has reached N.
`timescale 1ns/100ps

module e1ai_run_count #(
  parameter int unsigned N = 2,
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Step
  input  wire logic         step,
  input  wire logic         hit,
  // Result
  output logic              done
);

  localparam logic [W-1:0] LIMIT = W'(N);

  logic [W-1:0] run;
  wire          at_limit = (run == LIMIT);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run <= '0;
    end else if (step) begin
      run <= !hit ? '0 : (at_limit ? run : run + W'(1));
    end
  end

  assign done = at_limit;

endmodule

// >>> logic/e1ai_alarm_irq.sv
// E1 receive alarm monitor with block/source interrupt gating and a host register port.
// Assumes upstream framing supplies bit, frame, FAS and multiframe y-bit strobes on clk,
// and that the host never raises both strobes in one cycle.
`timescale 1ns/100ps
`include "e1ai_cfg.svh"

module e1ai_alarm_irq (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Host register port
  input  wire logic [`E1AI_ADDR_W-1:0]  addr,
  input  wire logic [`E1AI_DATA_W-1:0]  wr_data,
  input  wire logic                     wr_en,
  input  wire logic                     rd_en,
  output logic      [`E1AI_DATA_W-1:0]  rd_data,
  // Receive line bits
  input  wire logic                     line_bit_valid,
  input  wire logic                     line_bit,
  input  wire logic                     frame_start,
  // Frame alignment checks
  input  wire logic                     fas_check,
  input  wire logic                     fas_errored,
  // Multiframe y bit
  input  wire logic                     mf_y_valid,
  input  wire logic                     mf_y_bit,
  // Interrupt
  output logic                          irq
);

  // Only the bits that exist are stored; the rest of each word reads as zero
  // Control registers
  logic [1:0]              block_interrupt_enable;
  logic [`E1AI_EV_W-1:0]   event_enable;
  logic [2:0]              frame_loss_threshold;

  // Alarm state and flags
  logic                    out_of_frame_state;
  logic                    all_ones_alarm_state;
  logic                    mf_yellow_state;
  logic                    mf_yellow_change_flag;
  e1ai_pkg::e1ai_los_t     los_fsm;
  logic [`E1AI_EV_W-1:0]   event_status;
  logic [2:0]              fas_err_run;
  logic [8:0]              frame_zeros;
  logic                    framed;
  logic [7:0]              los_bit_idx;
  logic [7:0]              los_ones;

  // Register decode
  // addr is a word index decoded in full, so no offset has an alias
  wire hit_block = (addr == `E1AI_OFS_BLOCK_EN);
  wire hit_stat  = (addr == `E1AI_OFS_STATUS);
  wire hit_event = (addr == `E1AI_OFS_EVENT);
  wire hit_clr   = (addr == `E1AI_OFS_EVENT_CLR);
  wire hit_en    = (addr == `E1AI_OFS_EVENT_EN);
  wire hit_frm   = (addr == `E1AI_OFS_FRAMING);
  wire wr_block  = wr_en & hit_block;
  wire wr_clr    = wr_en & hit_clr;
  wire wr_ev_en  = wr_en & hit_en;
  wire wr_frm    = wr_en & hit_frm;
  wire rd_stat   = rd_en & hit_stat;

  wire signal_loss_state = (los_fsm == e1ai_pkg::E1AI_LOS_DECLARED);

  // Status register view: live states plus the read-clear yellow change flag
  wire [`E1AI_DATA_W-1:0] status_word = {out_of_frame_state,
                                         all_ones_alarm_state,
                                         mf_yellow_change_flag,
                                         signal_loss_state,
                                         4'h0};

  // Event-clear and unmapped offsets read as zero
  wire [`E1AI_DATA_W-1:0] rd_mux =
      hit_block ? {6'h00, block_interrupt_enable} :
      hit_stat  ? status_word :
      hit_event ? {4'h0, event_status} :
      hit_en    ? {4'h0, event_enable} :
      hit_frm   ? {5'h00, frame_loss_threshold} :
                  8'h00;

  // Out of frame: a zero threshold behaves as one.
  // The run saturates at seven so a long errored stretch never wraps below the limit.
  // Lowering the threshold mid-run declares at the next errored pattern, not at once.
  wire [2:0] fas_limit    = (frame_loss_threshold == 3'h0) ? 3'h1 : frame_loss_threshold;
  wire [2:0] fas_run_inc  = (fas_err_run == 3'h7) ? fas_err_run : fas_err_run + 3'h1;
  wire [2:0] next_fas_run = !fas_check ? fas_err_run : (fas_errored ? fas_run_inc : 3'h0);
  wire       fas_hit      = (fas_run_inc >= fas_limit);
  wire       next_oof     = !fas_check ? out_of_frame_state :
                            fas_errored ? (out_of_frame_state | fas_hit) :
                            1'b0;

  // AIS: zeros per frame, judged when the next frame begins.
  // The part frame before the first frame_start is never judged, so AIS cannot
  // be declared from a stretch shorter than two whole frames.
  wire       bit_zero     = line_bit_valid & ~line_bit;
  wire       frame_end    = line_bit_valid & frame_start & framed;
  wire       frame_quiet  = (frame_zeros <= 9'(`E1AI_AIS_ZERO_MAX));
  wire       ais_set_done;
  wire       ais_clr_done;
  wire [8:0] zeros_inc    = (frame_zeros == 9'h1ff) ? frame_zeros : frame_zeros + 9'h1;
  wire [8:0] next_zeros   = !line_bit_valid ? frame_zeros :
                            frame_start ? {8'h00, ~line_bit} :
                            (bit_zero ? zeros_inc : frame_zeros);
  wire       ais_declare  = ~all_ones_alarm_state & ais_set_done;
  wire       ais_release  = all_ones_alarm_state & ais_clr_done;
  wire       next_ais     = (all_ones_alarm_state | ais_declare) & ~ais_release;

  // The set run keeps done through later quiet frames, so release needs its own run
  e1ai_run_count #(
    .N (`E1AI_AIS_FRAMES),
    .W (2)
  ) u_ais_set (
    .clk  (clk),
    .rst  (rst),
    .step (frame_end),
    .hit  (frame_quiet),
    .done (ais_set_done)
  );

  e1ai_run_count #(
    .N (`E1AI_AIS_FRAMES),
    .W (2)
  ) u_ais_clr (
    .clk  (clk),
    .rst  (rst),
    .step (frame_end),
    .hit  (~frame_quiet),
    .done (ais_clr_done)
  );

  // Loss of signal: zero run, plus fixed 175-bit ones-density windows.
  // Fixed windows instead of a sliding one save a 175-bit shift register; the price
  // is that a clear may wait for up to two windows after the ones return.
  // The zero-run counter is registered, so declaring lags the last zero by one edge.
  wire       los_run_done;
  wire       win_last     = (los_bit_idx == 8'(`E1AI_LOS_BITS - 1));
  wire [7:0] ones_now     = los_ones + {7'h00, line_bit};
  wire       density_ok   = line_bit_valid & win_last & (ones_now >= 8'(`E1AI_LOS_ONES_MIN));
  wire [7:0] next_bit_idx = !line_bit_valid ? los_bit_idx : (win_last ? 8'h00 : los_bit_idx + 8'h01);
  wire [7:0] next_ones    = !line_bit_valid ? los_ones : (win_last ? 8'h00 : ones_now);

  e1ai_run_count #(
    .N (`E1AI_LOS_BITS),
    .W (8)
  ) u_los_run (
    .clk  (clk),
    .rst  (rst),
    .step (line_bit_valid),
    .hit  (~line_bit),
    .done (los_run_done)
  );

  e1ai_pkg::e1ai_los_t next_los;
  always_comb begin
    next_los = los_fsm;
    case (los_fsm)
      e1ai_pkg::E1AI_LOS_CLEAR: begin
        if (los_run_done) begin
          next_los = e1ai_pkg::E1AI_LOS_DECLARED;
        end
      end
      e1ai_pkg::E1AI_LOS_DECLARED: begin
        if (density_ok) begin
          next_los = e1ai_pkg::E1AI_LOS_CLEAR;
        end
      end
      default: begin
        next_los = e1ai_pkg::E1AI_LOS_CLEAR;
      end
    endcase
  end

  // Yellow alarm tracks each received y bit
  // A repeated y bit is no change and leaves the flag alone
  wire next_yellow = mf_y_valid ? mf_y_bit : mf_yellow_state;
  wire myel_chg    = next_yellow ^ mf_yellow_state;

  // Change events; a set in the clearing cycle survives
  // Event bits follow the next state, so they set in the edge the state moves
  wire next_los_on = (next_los == e1ai_pkg::E1AI_LOS_DECLARED);
  wire [`E1AI_EV_W-1:0] ev_set = {next_los_on ^ signal_loss_state,
                                  myel_chg,
                                  next_ais ^ all_ones_alarm_state,
                                  next_oof ^ out_of_frame_state};
  wire [`E1AI_EV_W-1:0] ev_clr   = wr_clr ? wr_data[`E1AI_EV_W-1:0] : 4'h0;
  wire [`E1AI_EV_W-1:0] next_ev  = (event_status & ~ev_clr) | ev_set;
  wire                  myel_set = myel_chg & event_enable[`E1AI_EV_MYEL];
  wire next_myel_flag = myel_set | (mf_yellow_change_flag & ~rd_stat);

  // Interrupt gating: source enable and group block enable both required.
  // The yellow change flag is a second framer source beside its sticky event bit,
  // so a status read that clears the flag leaves the event bit holding the pin.
  // An enable write reaches the pin one edge after the write is taken.
  wire                  framer_blk  = block_interrupt_enable[`E1AI_BIT_FRAMER_BLK];
  wire                  alarm_blk   = block_interrupt_enable[`E1AI_BIT_ALARM_BLK];
  wire [`E1AI_EV_W-1:0] src_pend    = next_ev & event_enable;
  wire                  framer_src  = |(src_pend & `E1AI_EV_FRAMER_MASK);
  wire                  alarm_src   = |(src_pend & `E1AI_EV_ALARM_MASK);
  wire                  myel_src    = next_myel_flag & event_enable[`E1AI_EV_MYEL];
  wire                  framer_pend = framer_blk & (framer_src | myel_src);
  wire                  alarm_pend  = alarm_blk & alarm_src;
  wire                  next_irq    = framer_pend | alarm_pend;

  // Host-written control
  // Read-only offsets are dropped by the decode, so no write can reach a state bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      block_interrupt_enable <= `E1AI_RST_BLOCK_EN;
      event_enable           <= `E1AI_RST_EVENT_EN;
      frame_loss_threshold   <= `E1AI_RST_THRESHOLD;
    end else begin
      if (wr_block) begin
        block_interrupt_enable <= wr_data[1:0];
      end
      if (wr_ev_en) begin
        event_enable <= wr_data[`E1AI_EV_W-1:0];
      end
      if (wr_frm) begin
        frame_loss_threshold <= wr_data[2:0];
      end
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= rd_en ? rd_mux : 8'h00;
    end
  end

  // Framing counters
  // The next values hold between line strobes, so idle cycles leave the counts alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fas_err_run <= 3'h0;
      frame_zeros <= 9'h000;
      los_bit_idx <= 8'h00;
      los_ones    <= 8'h00;
    end else begin
      fas_err_run <= next_fas_run;
      frame_zeros <= next_zeros;
      los_bit_idx <= next_bit_idx;
      los_ones    <= next_ones;
    end
  end

  // Frame judging starts after the first frame boundary
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      framed <= 1'b0;
    end else if (line_bit_valid & frame_start) begin
      framed <= 1'b1;
    end
  end

  // Alarm states
  // LOS moves through its two-state machine; the others are plain next-state flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_of_frame_state   <= 1'b0;
      all_ones_alarm_state <= 1'b0;
      mf_yellow_state      <= 1'b0;
      los_fsm              <= e1ai_pkg::E1AI_LOS_CLEAR;
    end else begin
      out_of_frame_state   <= next_oof;
      all_ones_alarm_state <= next_ais;
      mf_yellow_state      <= next_yellow;
      los_fsm              <= next_los;
    end
  end

  // Sticky flags and the interrupt pin
  // irq is taken from next values so it moves in the same edge as the flag it shows
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      event_status          <= 4'h0;
      mf_yellow_change_flag <= 1'b0;
      irq                   <= 1'b0;
    end else begin
      event_status          <= next_ev;
      mf_yellow_change_flag <= next_myel_flag;
      irq                   <= next_irq;
    end
  end

endmodule

// >>> testbench/e1ai_line_model.sv
// Receive line source: one bit per clock in 256-bit frames.
// Assumes mode from the bench: 0 idle, 1 zeros, 2 ones.
`timescale 1ns/100ps
module e1ai_line_model (
  // Clock and control
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] mode,
  // Line
  output logic            line_bit_valid,
  output logic            line_bit,
  output logic            frame_start
);
  logic [7:0] pos;
  wire        run = mode != 2'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos            <= 8'h00;
      line_bit_valid <= 1'b0;
      line_bit       <= 1'b0;
      frame_start    <= 1'b0;
    end else begin
      line_bit_valid <= run;
      // Idle line toggles so a stale value is never mistaken for data
      line_bit       <= run ? mode[1] : ~line_bit;
      frame_start    <= run && pos == 8'h00;
      if (run)
        pos <= pos + 8'h01;
    end
  end
endmodule

// >>> testbench/e1ai_alarm_irq_assertions.sv
// Port checker for e1ai_alarm_irq.
// Assumes one clock domain; bound to every instance.
`timescale 1ns/100ps
module e1ai_chk (
  // Clock, reset and host port
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rd_data,
  // Line and pin
  input wire logic       line_bit_valid,
  input wire logic       line_bit,
  input wire logic       fas_check,
  input wire logic       fas_errored,
  input wire logic       mf_y_valid,
  input wire logic       irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [1:0] blk;
  logic [3:0] en;
  logic [7:0] zr;
  wire        st_rd = rd_en && addr == 4'h1;
  wire        quiet = !wr_en && !rd_en && !fas_check && !mf_y_valid && !line_bit_valid;

  // Shadow enables and a saturating zero-run count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blk <= 2'h0;
      en  <= 4'h0;
      zr  <= 8'h00;
    end else begin
      if (wr_en && addr == 4'h0)
        blk <= wr_data[1:0];
      if (wr_en && addr == 4'h4)
        en <= wr_data[3:0];
      if (line_bit_valid)
        zr <= line_bit ? 8'h00 : zr + {7'h00, zr != 8'hff};
    end
  end

  a_blk_off_quiet: assert property (blk == 2'h0 |=> !irq) else $error("irq with groups off");
  a_src_off_quiet: assert property (en == 4'h0 |=> !irq) else $error("irq with sources off");
  a_rd_idle_zero: assert property (!rd_en |=> rd_data == 8'h00) else $error("stray read data");
  a_stat_low_zero: assert property (st_rd |=> rd_data[3:0] == 4'h0) else $error("status low bits");
  a_oof_good_clear: assert property (
    fas_check && !fas_errored ##1 !fas_check ##1 st_rd && !fas_check |=> !rd_data[7])
    else $error("frame loss after good pattern");
  a_myel_read_clear: assert property (
    st_rd && !mf_y_valid ##1 st_rd && !mf_y_valid |=> !rd_data[5])
    else $error("yellow flag survived read");
  a_los_long_zero: assert property (st_rd && zr >= 8'hb4 |=> rd_data[4]) else $error("no signal loss");
  a_irq_hold_quiet: assert property (irq && quiet && !$past(wr_en) |=> irq) else $error("irq dropped");
endmodule

bind e1ai_alarm_irq e1ai_chk i_e1ai_chk (
  .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data(rd_data), .line_bit_valid(line_bit_valid), .line_bit(line_bit),
  .fas_check(fas_check), .fas_errored(fas_errored), .mf_y_valid(mf_y_valid), .irq(irq)
);

// >>> testbench/e1ai_alarm_irq_bench.sv
// Self-checking bench for e1ai_alarm_irq with a line source model.
// Assumes the host map 4'h0..4'h5; a bit model tracks the status register.
`timescale 1ns/100ps
module e1ai_alarm_irq_bench;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wr_data = 8'h00;
  logic       wr_en = 1'b0;
  logic       rd_en = 1'b0;
  logic       fas_check = 1'b0;
  logic       fas_errored = 1'b0;
  logic       mf_y_valid = 1'b0;
  logic       mf_y_bit = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [7:0] rd_data;
  logic [7:0] got;
  logic [7:0] r;
  logic       line_bit_valid;
  logic       line_bit;
  logic       frame_start;
  logic       irq;
  logic       m_oof = 1'b0;
  logic       m_ais = 1'b0;
  logic       m_myel = 1'b0;
  logic       m_los = 1'b0;
  int         n_fail = 0;
  int         num_checks = 0;

  always #2.5 clk = ~clk;

  e1ai_alarm_irq i_e1ai_alarm_irq (
    .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .line_bit_valid(line_bit_valid), .line_bit(line_bit),
    .frame_start(frame_start), .fas_check(fas_check), .fas_errored(fas_errored),
    .mf_y_valid(mf_y_valid), .mf_y_bit(mf_y_bit), .irq(irq)
  );
  e1ai_line_model i_e1ai_line_model (
    .clk(clk), .rst(rst), .mode(mode), .line_bit_valid(line_bit_valid),
    .line_bit(line_bit), .frame_start(frame_start)
  );

  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // n gap-free reads of one address; got holds the last answer
  task automatic rd(input logic [3:0] a, input int n);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    repeat (n) @(posedge clk);
    rd_en <= 1'b0;
    #1 got = rd_data;
  endtask
  task automatic chk_stat(input int n);
    rd(4'h1, n);
    cmp(got, {m_oof, m_ais, m_myel && n == 1, m_los, 4'h0});
    m_myel = 1'b0;
  endtask
  // f=1: pattern check with errored=v; f=0: y bit v
  task automatic pulse(input logic f, input logic v);
    @(posedge clk);
    fas_check <= f;
    fas_errored <= v;
    mf_y_valid <= !f;
    mf_y_bit <= v;
    @(posedge clk);
    fas_check <= 1'b0;
    mf_y_valid <= 1'b0;
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    #1 cmp({7'h00, irq}, {7'h00, e});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run;
  end

  initial begin
    r = 8'($urandom(57));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), 1);
      cmp(got, (a == 5) ? 8'h02 : 8'h00);
      r = 8'($urandom);
      wr(4'(a), r);
      rd(4'(a), 1);
      cmp(got, r & ((a == 0) ? 8'h03 : (a == 4) ? 8'h0f : (a == 5) ? 8'h07 : 8'h00));
    end
    $display("test registers done");
    wr(4'h4, 8'h00);
    wr(4'h0, 8'h01);
    wr(4'h5, 8'h03);
    pulse(1, 1);
    pulse(1, 1);
    chk_stat(1);
    pulse(1, 1);
    m_oof = 1'b1;
    chk_stat(1);
    rd(4'h2, 1);
    cmp(got, 8'h01);
    irq_is(0);
    wr(4'h4, 8'h01);
    irq_is(1);
    wr(4'h0, 8'h02);
    irq_is(0);
    pulse(1, 0);
    m_oof = 1'b0;
    chk_stat(1);
    // A zero threshold declares on the first errored pattern
    wr(4'h5, 8'h00);
    pulse(1, 1);
    m_oof = 1'b1;
    chk_stat(1);
    pulse(1, 0);
    m_oof = 1'b0;
    chk_stat(1);
    $display("test frame loss done");
    wr(4'h3, 8'h0f);
    wr(4'h4, 8'h04);
    wr(4'h0, 8'h01);
    pulse(0, 1);
    m_myel = 1'b1;
    irq_is(1);
    chk_stat(1);
    pulse(0, 1);
    chk_stat(2);
    wr(4'h4, 8'h00);
    pulse(0, 0);
    chk_stat(1);
    $display("test yellow done");
    wr(4'h3, 8'h0f);
    wr(4'h4, 8'h0a);
    wr(4'h0, 8'h02);
    mode <= 2'h1;
    repeat (200) @(posedge clk);
    m_los = 1'b1;
    chk_stat(1);
    irq_is(1);
    wr(4'h0, 8'h00);
    irq_is(0);
    wr(4'h3, 8'h0f);
    wr(4'h0, 8'h02);
    irq_is(0);
    // 900 cycles spans a split frame plus two whole frames and two loss windows
    mode <= 2'h2;
    repeat (900) @(posedge clk);
    m_los = 1'b0;
    m_ais = 1'b1;
    chk_stat(1);
    rd(4'h2, 1);
    cmp(got, 8'h0a);
    irq_is(1);
    mode <= 2'h1;
    repeat (900) @(posedge clk);
    m_los = 1'b1;
    m_ais = 1'b0;
    chk_stat(1);
    mode <= 2'h0;
    $display("test line alarms done");
    complete_run;
  end
endmodule
